// *** common/flow_ctrl_cfg.svh ***
// register offsets, field values and timing counts for the flow-control block
`ifndef FLOW_CTRL_CFG_SVH
`define FLOW_CTRL_CFG_SVH
`define FC_OFS_RX_FIRST     8'h01
`define FC_OFS_RX_END       8'h02
`define FC_OFS_JAM_LIMIT    8'h17
`define FC_OFS_WATER_MARK   8'h1a
`define FC_OFS_STATUS       8'h1b
`define FC_OFS_MODE         8'h1c
`define FC_RST_RX_FIRST     8'h46
`define FC_RST_RX_END       8'h80
`define FC_RST_JAM_LIMIT    8'h10
`define FC_RST_WATER_MARK   8'h08
`define FC_RST_MODE         8'h00
`define FC_MCAST_DA         48'h0180_c200_0001
`define FC_CTRL_TYPE        16'h8808
`define FC_PAUSE_OPCODE     16'h0001
`define FC_PAD_ZEROS        42
`define FC_XOFF_HYST        8'h06
`define FC_QUANTUM_BITS     512
`define FC_CLK_MHZ          250
`define FC_QUANTUM_CYC_100  ((`FC_QUANTUM_BITS * `FC_CLK_MHZ + 99) / 100)
`define FC_QUANTUM_CYC_10   ((`FC_QUANTUM_BITS * `FC_CLK_MHZ + 9) / 10)
`endif

// *** common/flow_ctrl_pkg.sv ***
// types shared by the flow-control block
package flow_ctrl_pkg;
   typedef struct packed {
      logic        valid;
      logic        fcs_ok;
      logic [47:0] dst;
      logic [15:0] len_type;
      logic [15:0] opcode;
      logic [15:0] param;
   } rx_ctrl_t;
   typedef struct packed {
      logic        send;
      logic        xon;
      logic [47:0] dst;
      logic [15:0] len_type;
      logic [15:0] opcode;
      logic [15:0] param;
      logic [5:0]  pad_len;
   } tx_pause_t;
   typedef enum logic [2:0] {
      PS_IDLE = 3'b001,
      PS_WAIT = 3'b010,
      PS_RUN  = 3'b100
   } pause_state_t;
endpackage

// *** logic/ethernet_flow_control.sv ***
// flow control: pause reception, xon/xoff emission and half-duplex back-pressure
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`include "flow_ctrl_cfg.svh"
module ethernet_flow_control
#(
   parameter int Q100 = `FC_QUANTUM_CYC_100,
   parameter int Q10  = `FC_QUANTUM_CYC_10
)
(
   // clock, reset, enable
   input  wire logic                    clk,
   input  wire logic                    rst_n,
   input  wire logic                    clk_en,
   // register port
   input  wire logic [7:0]              reg_addr,
   input  wire logic [7:0]              reg_wdata,
   input  wire logic                    reg_wr,
   input  wire logic                    reg_rd,
   output logic      [7:0]              reg_rdata,
   // link mode and station address
   input  wire logic                    full_duplex,
   input  wire logic                    speed_100,
   input  wire logic [47:0]             station_addr,
   // receive side
   input  wire flow_ctrl_pkg::rx_ctrl_t rx_ctrl,
   input  wire logic                    rx_start,
   input  wire logic                    rx_done,
   input  wire logic                    rx_collision,
   input  wire logic [7:0]              rx_write_page,
   input  wire logic [7:0]              rx_read_page,
   // transmit side
   input  wire logic                    tx_busy,
   input  wire logic                    tx_done,
   input  wire logic                    tx_collision,
   input  wire logic                    tx_pause_ack,
   output logic                         tx_hold,
   output flow_ctrl_pkg::tx_pause_t     tx_pause,
   output logic                         jam
);
   import flow_ctrl_pkg::*;

   // ----------------------------------------
   // registers
   // ----------------------------------------
   // ring bounds, jam limit, water mark and mode bit
   logic [7:0] first_q, first_d, end_q, end_d, lim_q, lim_d, wm_q, wm_d;
   logic       wm_en_q, wm_en_d;
   logic [7:0] rdata_q, rdata_d;

   // software writes; status register is read only
   always_comb
   begin
      first_d = first_q;
      end_d   = end_q;
      lim_d   = lim_q;
      wm_d    = wm_q;
      wm_en_d = wm_en_q;
      if (reg_wr)
      begin
         case (reg_addr)
            `FC_OFS_RX_FIRST:   first_d = reg_wdata;
            `FC_OFS_RX_END:     end_d   = reg_wdata;
            `FC_OFS_JAM_LIMIT:  lim_d   = reg_wdata;
            `FC_OFS_WATER_MARK: wm_d    = reg_wdata;
            `FC_OFS_MODE:       wm_en_d = reg_wdata[0];
            default:            ;
         endcase
      end
   end

   // register bank and read data, frozen with the enable
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         first_q <= `FC_RST_RX_FIRST;
         end_q   <= `FC_RST_RX_END;
         lim_q   <= `FC_RST_JAM_LIMIT;
         wm_q    <= `FC_RST_WATER_MARK;
         wm_en_q <= 1'b0;
         rdata_q <= 8'h00;
      end
      else if (clk_en)
      begin
         first_q <= first_d;
         end_q   <= end_d;
         lim_q   <= lim_d;
         wm_q    <= wm_d;
         wm_en_q <= wm_en_d;
         rdata_q <= rdata_d;
      end
   end
   // read data stands one cycle, zero otherwise
   assign reg_rdata = rdata_q;

   // ----------------------------------------
   // free page count
   // ----------------------------------------
   logic [7:0] ring_pages, used_pages, free_pages;
   logic       buf_low;
   // a write pointer behind the read pointer has wrapped round the ring
   always_comb
   begin
      ring_pages = end_q - first_q;
      if (rx_write_page >= rx_read_page)
         used_pages = rx_write_page - rx_read_page;
      else
         used_pages = ring_pages - (rx_read_page - rx_write_page);
      free_pages = ring_pages - used_pages;
      buf_low    = (free_pages <= wm_q);
   end

   // ----------------------------------------
   // pause reception and timer
   // ----------------------------------------
   // control frame that asks this station to pause
   function automatic logic pause_hit(input rx_ctrl_t f, input logic [47:0] own);
      pause_hit = f.valid && f.fcs_ok
                  && (f.dst == own || f.dst == `FC_MCAST_DA)
                  && f.len_type == `FC_CTRL_TYPE
                  && f.opcode == `FC_PAUSE_OPCODE;
   endfunction

   // pause timer: quanta left and cycles left in the current quantum
   pause_state_t ps_q, ps_d;
   logic [15:0]  quanta_q, quanta_d;
   logic [15:0]  sub_q, sub_d;
   logic [15:0]  qlen;
   logic         hit;

   // next state of the pause timer
   always_comb
   begin
      hit      = full_duplex && pause_hit(rx_ctrl, station_addr);
      qlen     = speed_100 ? 16'(Q100 - 1) : 16'(Q10 - 1);
      ps_d     = ps_q;
      quanta_d = quanta_q;
      sub_d    = sub_q;
      case (ps_q)
         PS_IDLE:
            ps_d = PS_IDLE;
         // a deferred pause starts once the frame on the wire has ended
         PS_WAIT:
         begin
            if (!tx_busy)
            begin
               ps_d  = (quanta_q == 16'h0000) ? PS_IDLE : PS_RUN;
               sub_d = qlen;
            end
         end
         // sub walks the cycles of one quantum, quanta the quanta left
         PS_RUN:
         begin
            if (sub_q != 16'h0000)
               sub_d = sub_q - 16'h0001;
            else if (quanta_q <= 16'h0001)
            begin
               quanta_d = 16'h0000;
               ps_d     = PS_IDLE;
            end
            else
            begin
               quanta_d = quanta_q - 16'h0001;
               sub_d    = qlen;
            end
         end
         default:
            ps_d = PS_IDLE;
      endcase
      // a fresh request reloads the timer whatever state it was in
      if (hit)
      begin
         quanta_d = rx_ctrl.param;
         sub_d    = qlen;
         if (rx_ctrl.param == 16'h0000)
            ps_d = PS_IDLE;
         else if (tx_busy)
            ps_d = PS_WAIT;
         else
            ps_d = PS_RUN;
      end
   end

   // pause timer registers
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ps_q     <= PS_IDLE;
         quanta_q <= 16'h0000;
         sub_q    <= 16'h0000;
      end
      else if (clk_en)
      begin
         ps_q     <= ps_d;
         quanta_q <= quanta_d;
         sub_q    <= sub_d;
      end
   end
   // holds off new frames only; a frame under way finishes first
   assign tx_hold = (ps_q == PS_RUN);

   // ----------------------------------------
   // xon / xoff emission
   // ----------------------------------------
   // request toward the mac and which of the pair goes next
   logic      xoff_sent_q, xoff_sent_d;
   tx_pause_t txp_q, txp_d;
   logic [8:0] xoff_level;

   // nothing new is raised while a request still waits for its ack
   always_comb
   begin
      xoff_level  = {1'b0, wm_q} + {1'b0, `FC_XOFF_HYST};
      xoff_sent_d = xoff_sent_q;
      txp_d       = txp_q;
      if (tx_pause_ack)
         txp_d.send = 1'b0;
      if (wm_en_q && full_duplex && !txp_q.send)
      begin
         if (!xoff_sent_q && buf_low)
         begin
            txp_d.send  = 1'b1;
            txp_d.xon   = 1'b1;
            xoff_sent_d = 1'b1;
         end
         else if (xoff_sent_q && {1'b0, free_pages} >= xoff_level)
         begin
            txp_d.send  = 1'b1;
            txp_d.xon   = 1'b0;
            xoff_sent_d = 1'b0;
         end
      end
      // frame labelled xon pauses the partner, the other releases it
      txp_d.param    = txp_d.xon ? 16'hffff : 16'h0000;
      txp_d.dst      = `FC_MCAST_DA;
      txp_d.len_type = `FC_CTRL_TYPE;
      txp_d.opcode   = `FC_PAUSE_OPCODE;
      txp_d.pad_len  = 6'(`FC_PAD_ZEROS);
   end

   // xon/xoff registers
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         xoff_sent_q <= 1'b0;
         txp_q       <= '0;
      end
      else if (clk_en)
      begin
         xoff_sent_q <= xoff_sent_d;
         txp_q       <= txp_d;
      end
   end
   // request and its fields stand until the mac acknowledges
   assign tx_pause = txp_q;

   // ----------------------------------------
   // half-duplex back-pressure
   // ----------------------------------------
   // run of back-pressure collisions and the jam itself
   logic [7:0] jcnt_q, jcnt_d;
   logic       jam_q, jam_d;

   // jamming only at frame start avoids late collisions
   always_comb
   begin
      jcnt_d = jcnt_q;
      jam_d  = jam_q;
      if (rx_done)
         jam_d = 1'b0;
      if ((tx_done && !tx_collision) || (rx_done && !rx_collision && !jam_q))
         jcnt_d = 8'h00;
      if (!full_duplex && rx_start && buf_low)
      begin
         // one frame leaks through so the far hub never partitions the port
         if (jcnt_q >= lim_q)
         begin
            jcnt_d = 8'h00;
         end
         else
         begin
            jam_d  = 1'b1;
            jcnt_d = jcnt_q + 8'h01;
         end
      end
   end

   // back-pressure registers
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         jcnt_q <= 8'h00;
         jam_q  <= 1'b0;
      end
      else if (clk_en)
      begin
         jcnt_q <= jcnt_d;
         jam_q  <= jam_d;
      end
   end
   // jam stands from frame start to frame end
   assign jam = jam_q;

   // ----------------------------------------
   // read data
   // ----------------------------------------
   // unmapped offsets and idle cycles read as zero
   always_comb
   begin
      rdata_d = 8'h00;
      if (reg_rd)
      begin
         case (reg_addr)
            `FC_OFS_RX_FIRST:   rdata_d = first_q;
            `FC_OFS_RX_END:     rdata_d = end_q;
            `FC_OFS_JAM_LIMIT:  rdata_d = lim_q;
            `FC_OFS_WATER_MARK: rdata_d = wm_q;
            `FC_OFS_STATUS:     rdata_d = free_pages;
            `FC_OFS_MODE:       rdata_d = {5'h00, tx_hold, xoff_sent_q, wm_en_q};
            default:            rdata_d = 8'h00;
         endcase
      end
   end
endmodule

// *** verif/flow_ctrl_asserts.sv ***
// port-level assertions for the flow-control block
`timescale 1ns/1ps
`include "flow_ctrl_cfg.svh"
module flow_ctrl_asserts
#(
   parameter int Q100 = 4,
   parameter int Q10  = 40
)
(
   // clock and reset
   input wire logic                    clk,
   input wire logic                    rst_n,
   // watched ports
   input wire logic                    reg_rd,
   input wire logic [7:0]              reg_rdata,
   input wire logic                    full_duplex,
   input wire logic [47:0]             station_addr,
   input wire flow_ctrl_pkg::rx_ctrl_t rx_ctrl,
   input wire logic                    rx_start,
   input wire logic                    rx_done,
   input wire logic                    tx_busy,
   input wire logic                    tx_pause_ack,
   input wire logic                    tx_hold,
   input wire flow_ctrl_pkg::tx_pause_t tx_pause,
   input wire logic                    jam
);
   import flow_ctrl_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic good;
   // a pause request that must be obeyed
   assign good = rx_ctrl.valid && rx_ctrl.fcs_ok && full_duplex
      && (rx_ctrl.dst == `FC_MCAST_DA || rx_ctrl.dst == station_addr)
      && rx_ctrl.len_type == `FC_CTRL_TYPE && rx_ctrl.opcode == `FC_PAUSE_OPCODE;
   property p_rd_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data left standing");
   property p_hold; good && !tx_busy && rx_ctrl.param != 16'h0000 |=> tx_hold; endproperty
   a_hold: assert property (p_hold) else $error("pause not obeyed");
   property p_zero; good && !tx_busy && rx_ctrl.param == 16'h0000 |=> !tx_hold; endproperty
   a_zero: assert property (p_zero) else $error("zero pause kept hold");
   property p_defer; tx_busy && !tx_hold |=> !tx_hold; endproperty
   a_defer: assert property (p_defer) else $error("hold during transmit");
   property p_fields;
      tx_pause.send |-> tx_pause.len_type == `FC_CTRL_TYPE && tx_pause.opcode == `FC_PAUSE_OPCODE
         && tx_pause.pad_len == 6'(`FC_PAD_ZEROS) && tx_pause.dst == `FC_MCAST_DA;
   endproperty
   a_fields: assert property (p_fields) else $error("bad pause frame fields");
   property p_stand; tx_pause.send && !tx_pause_ack |=> tx_pause.send && $stable(tx_pause.xon);
   endproperty
   a_stand: assert property (p_stand) else $error("pause request dropped");
   property p_jam_start; $rose(jam) |-> $past(rx_start); endproperty
   a_jam_start: assert property (p_jam_start) else $error("jam outside frame start");
   property p_jam_end; jam && rx_done |=> !jam; endproperty
   a_jam_end: assert property (p_jam_end) else $error("jam past frame end");
endmodule

// *** verif/link_partner_model.sv ***
// remote station model: pause frames and incoming frames
`timescale 1ns/1ps
`include "flow_ctrl_cfg.svh"
module link_partner_model
(
   // clock
   input  wire logic                clk,
   // frames toward the block
   output flow_ctrl_pkg::rx_ctrl_t  rx_ctrl,
   output logic                     rx_start,
   output logic                     rx_done,
   output logic                     rx_collision,
   // back-pressure seen on the wire
   input  wire logic                jam
);
   import flow_ctrl_pkg::*;
   initial
   begin
      rx_ctrl      = '0;
      rx_start     = 1'b0;
      rx_done      = 1'b0;
      rx_collision = 1'b0;
   end
   // one control frame; fields scrambled after the pulse so stale values never match
   task send_pause(input logic [47:0] da, input logic [15:0] op, input logic [15:0] prm,
                   input logic ok);
      @(posedge clk);
      rx_ctrl <= '{1'b1, ok, da, `FC_CTRL_TYPE, op, prm};
      @(posedge clk);
      rx_ctrl <= {1'b0, ~rx_ctrl[$bits(rx_ctrl_t)-2:0]};
   endtask
   // one incoming frame, collided when coll is set; jam is sampled one cycle after the start
   task frame(input logic coll, output logic jammed);
      @(posedge clk);
      rx_start <= 1'b1;
      @(posedge clk);
      rx_start <= 1'b0;
      #1 jammed = jam;
      repeat (3) @(posedge clk);
      rx_done      <= 1'b1;
      rx_collision <= coll;
      @(posedge clk);
      rx_done      <= 1'b0;
      rx_collision <= 1'b0;
   endtask
endmodule

// *** verif/testbench.sv ***
// self-checking bench for the flow-control block
`timescale 1ns/1ps
`include "flow_ctrl_cfg.svh"
module testbench;
   import flow_ctrl_pkg::*;
   localparam int Q  = 4;  // shortened quantum at 100 Mb/s
   localparam int QS = 40; // shortened quantum at 10 Mb/s
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic        full_duplex = 1'b1;
   logic        speed_100 = 1'b1;
   logic        tx_busy = 1'b0;
   logic        tx_done = 1'b0;
   logic        tx_pause_ack = 1'b0;
   logic        tx_collision = 1'b0;
   logic        clk_en = 1'b1;
   logic        tx_hold, jam, rx_start, rx_done, rx_collision;
   logic [7:0]  reg_addr = 8'h00;
   logic [7:0]  reg_wdata = 8'h00;
   logic [7:0]  rx_write_page = 8'h00;
   logic [7:0]  rx_read_page = 8'h00;
   logic [7:0]  reg_rdata;
   logic [47:0] station_addr = 48'h0200_0000_0a01;
   rx_ctrl_t    rx_ctrl;
   tx_pause_t   tx_pause;
   int          fails = 0;
   int          n_tests = 0;
   always #2 clk = ~clk;
   ethernet_flow_control #(.Q100(Q), .Q10(QS)) i_ethernet_flow_control (.clk, .rst_n,
      .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .full_duplex,
      .speed_100, .station_addr, .rx_ctrl, .rx_start, .rx_done, .rx_collision, .rx_write_page,
      .rx_read_page, .tx_busy, .tx_done, .tx_collision, .tx_pause_ack, .tx_hold,
      .tx_pause, .jam);
   link_partner_model i_link_partner_model (.clk, .rx_ctrl, .rx_start, .rx_done,
      .rx_collision, .jam);
   task check(input logic [47:0] got, input logic [47:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         fails++;
         $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
      end
   endtask
   task report_and_stop;
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk) reg_wr <= 1'b0;
   endtask
   task rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk) reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   // pause frame from the partner, then look at the hold
   task pz(input logic [47:0] da, input logic [15:0] op, input logic [15:0] prm,
           input logic ok, input logic exp);
      i_link_partner_model.send_pause(da, op, prm, ok);
      #1 check(tx_hold, exp);
   endtask
   // cycles until the hold lifts, capped so a stuck hold cannot hang
   task hold_len(input int lo, input int hi);
      int n;
      n = 0;
      while (tx_hold === 1'b1 && n < 2000)
      begin
         @(posedge clk);
         #1 n++;
      end
      check(n inside {[lo:hi]}, 1'b1);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task t_regs;
      logic [7:0] d;
      logic [7:0] ofs [4];
      logic [7:0] rv [4];
      ofs = '{`FC_OFS_RX_FIRST, `FC_OFS_RX_END, `FC_OFS_JAM_LIMIT, `FC_OFS_WATER_MARK};
      rv  = '{`FC_RST_RX_FIRST, `FC_RST_RX_END, `FC_RST_JAM_LIMIT, `FC_RST_WATER_MARK};
      for (int i = 0; i < 4; i++)
      begin
         rd(ofs[i], d);
         check(d, rv[i]);
         wr(ofs[i], 8'ha5);
         rd(ofs[i], d);
         check(d, 8'ha5);
         wr(ofs[i], rv[i]);
      end
      wr(8'h30, 8'hff);
      rd(8'h30, d);
      check(d, 8'h00);
      // a frozen block ignores a write
      @(posedge clk) clk_en <= 1'b0;
      wr(`FC_OFS_RX_FIRST, 8'h11);
      clk_en <= 1'b1;
      rd(`FC_OFS_RX_FIRST, d);
      check(d, `FC_RST_RX_FIRST);
      // read pointer ahead of write pointer: the gap between them is free
      @(posedge clk) rx_read_page <= 8'h10;
      rx_write_page <= 8'h08;
      rd(`FC_OFS_STATUS, d);
      check(d, 8'h08);
      @(posedge clk) rx_read_page <= 8'h00;
      rx_write_page <= 8'h00;
   endtask
   task t_pause;
      pz(`FC_MCAST_DA, `FC_PAUSE_OPCODE, 16'h0002, 1'b1, 1'b1);
      hold_len(2 * Q, 2 * Q + 2);
      pz(`FC_MCAST_DA, `FC_PAUSE_OPCODE, 16'h0005, 1'b0, 1'b0);
      pz(48'h0180_c200_0002, `FC_PAUSE_OPCODE, 16'h0005, 1'b1, 1'b0);
      pz(`FC_MCAST_DA, 16'h0002, 16'h0005, 1'b1, 1'b0);
      pz(station_addr, `FC_PAUSE_OPCODE, 16'h0100, 1'b1, 1'b1);
      pz(`FC_MCAST_DA, `FC_PAUSE_OPCODE, 16'h0001, 1'b1, 1'b1);
      hold_len(Q, Q + 2);
      pz(`FC_MCAST_DA, `FC_PAUSE_OPCODE, 16'hffff, 1'b1, 1'b1);
      pz(`FC_MCAST_DA, `FC_PAUSE_OPCODE, 16'h0000, 1'b1, 1'b0);
      @(posedge clk) speed_100 <= 1'b0;
      pz(`FC_MCAST_DA, `FC_PAUSE_OPCODE, 16'h0001, 1'b1, 1'b1);
      hold_len(QS, QS + 2);
      @(posedge clk) speed_100 <= 1'b1;
      // pause while a frame is going out waits for its end
      @(posedge clk) tx_busy <= 1'b1;
      pz(`FC_MCAST_DA, `FC_PAUSE_OPCODE, 16'h0001, 1'b1, 1'b0);
      repeat (3) @(posedge clk);
      #1 check(tx_hold, 1'b0);
      @(posedge clk) tx_busy <= 1'b0;
      tx_done <= 1'b1;
      @(posedge clk) tx_done <= 1'b0;
      @(posedge clk);
      #1 check(tx_hold, 1'b1);
      hold_len(1, Q + 2);
   endtask
   // free pages = 3ah - write page; water mark 8
   task xstep(input logic [7:0] wp, input logic [17:0] exp);
      @(posedge clk) rx_write_page <= wp;
      repeat (3) @(posedge clk);
      #1 check({tx_pause.send, tx_pause.xon, tx_pause.param}, exp);
   endtask
   task t_xon;
      logic [7:0] d;
      wr(`FC_OFS_MODE, 8'h01);
      xstep(8'h31, 18'h0_0000);
      xstep(8'h32, 18'h3_ffff);
      rd(`FC_OFS_STATUS, d);
      check(d, 8'h08);
      rd(`FC_OFS_MODE, d);
      check(d, 8'h03);
      @(posedge clk) tx_pause_ack <= 1'b1;
      @(posedge clk) tx_pause_ack <= 1'b0;
      xstep(8'h2d, 18'h1_ffff);
      xstep(8'h2c, 18'h2_0000);
      @(posedge clk) tx_pause_ack <= 1'b1;
      @(posedge clk) tx_pause_ack <= 1'b0;
      wr(`FC_OFS_MODE, 8'h00);
   endtask
   task t_jam;
      logic       j;
      logic [6:0] pat;
      pat = 7'b011_1011;
      @(posedge clk) full_duplex <= 1'b0;
      rx_write_page <= 8'h00;
      wr(`FC_OFS_JAM_LIMIT, 8'h02);
      i_link_partner_model.frame(1'b0, j);
      check(j, 1'b0);
      @(posedge clk) rx_write_page <= 8'h32;
      for (int i = 0; i < 7; i++)
      begin
         if (i == 1 || i == 4)
         begin
            // a collided transmit keeps the run of jams, a clean one clears it
            @(posedge clk) tx_done <= 1'b1;
            tx_collision <= (i == 1);
            @(posedge clk) tx_done <= 1'b0;
            tx_collision <= 1'b0;
         end
         i_link_partner_model.frame(pat[i], j);
         check(j, pat[i]);
      end
   endtask
   initial
   begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      t_regs;
      t_pause;
      t_xon;
      t_jam;
      report_and_stop;
   end
   // watchdog well beyond the expected run
   initial
   begin
      repeat (20000) @(posedge clk);
      fails++;
      report_and_stop;
   end
endmodule
bind ethernet_flow_control flow_ctrl_asserts #(.Q100(Q100), .Q10(Q10)) i_flow_ctrl_asserts
   (.clk, .rst_n, .reg_rd, .reg_rdata, .full_duplex, .station_addr, .rx_ctrl, .rx_start,
    .rx_done, .tx_busy, .tx_pause_ack, .tx_hold, .tx_pause, .jam);
